// ### kds_map.svh
/*
 * Constants of the key and display scanner: sizes, reset values, timing and key positions.
 * Assumes a 10 MHz system clock and a 1 MHz scan clock from the converter logic.
 */
`ifndef KDS_MAP_SVH
`define KDS_MAP_SVH

`define KDS_CLK_MHZ       10
`define KDS_SLOT_TICKS    250
`define KDS_SEL_W         3
`define KDS_NUM_DIGITS    8
`define KDS_NUM_RET       7
`define KDS_NUM_ROWS      3
`define KDS_NUM_KEYS      21
`define KDS_SEG_W         8
`define KDS_DEB_SCANS     4
`define KDS_STROBE_RST    8'h01
`define KDS_SEG_ALL       8'hFF
`define KDS_PULSE_MIN_US  50
`define KDS_PULSE_MAX_US  300
`define KDS_PULSE_US      100
`define KDS_PULSE_CYC     (`KDS_PULSE_US * `KDS_CLK_MHZ)
`define KDS_TEST_WIN_MS   1000
`define KDS_TEST_WIN_CYC  (`KDS_TEST_WIN_MS * 1000 * `KDS_CLK_MHZ)
`define KDS_KEY_REQUEST   0
`define KDS_KEY_RANGE20   10

`endif

// ### kds_pkg.sv
/*
 * Types of the key and display scanner.
 * Assumes kds_map.svh for the sizes.
 */
`include "kds_map.svh"
package kds_pkg;
    typedef enum logic [1:0] {
        ST_WINDOW  = 2'b00,
        ST_TEST    = 2'b01,
        ST_POWERUP = 2'b10,
        ST_NORMAL  = 2'b11
    } kds_state_e;
    typedef logic [`KDS_NUM_KEYS-1:0] kds_keys_t;
    typedef logic [`KDS_SEL_W-1:0]    kds_sel_t;
endpackage

// ### kds_keys_if.sv
/*
 * Carrier between the scanner and its key debouncer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`include "kds_map.svh"
interface kds_keys_if;
    import kds_pkg::*;
    logic                     sampleNow;
    kds_sel_t                 slot;
    logic [`KDS_NUM_RET-1:0]  returnLow;
    kds_keys_t                keysHeld;
    logic                     newPress;
    modport scanner  (output sampleNow, output slot, output returnLow, input keysHeld, input newPress);
    modport debounce (input sampleNow, input slot, input returnLow, output keysHeld, output newPress);
endinterface

// ### kds_debounce.sv
/*
 * Key matrix debouncer: one agreement counter per key position.
 * Assumes returnLow is already synchronised and sampleNow falls late in a strobe slot.
 */
`timescale 1ns/100ps
`include "kds_map.svh"
module kds_debounce #(
    parameter int DEB_SCANS = `KDS_DEB_SCANS
) (
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  ce,
    kds_keys_if.debounce keys
);
    import kds_pkg::*;
    kds_keys_t heldPrev;
    logic [3:0] cnt [`KDS_NUM_KEYS];

    genvar k;
    generate
        for (k = 0; k < `KDS_NUM_KEYS; k++) begin : g_key
            localparam int ROW  = k / `KDS_NUM_RET;
            localparam int LINE = k % `KDS_NUM_RET;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    cnt[k] <= 4'h0;
                    keys.keysHeld[k] <= 1'b0;
                end else if (ce && keys.sampleNow && keys.slot == 3'(ROW)) begin
                    if (keys.returnLow[LINE] == keys.keysHeld[k]) begin
                        cnt[k] <= 4'h0;
                    end else if (cnt[k] == 4'(DEB_SCANS - 1)) begin
                        cnt[k] <= 4'h0;
                        keys.keysHeld[k] <= keys.returnLow[LINE];
                    end else begin
                        cnt[k] <= cnt[k] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            heldPrev <= '0;
        end else if (ce) begin
            heldPrev <= keys.keysHeld;
        end
    end

    assign keys.newPress = |(keys.keysHeld & ~heldPrev);

    property p_held_on_sample;
        @(posedge clock) disable iff (rst)
            $changed(keys.keysHeld) |-> $past(keys.sampleNow) && $past(ce);
    endproperty
    a_held_on_sample: assert property (p_held_on_sample) else $error("key state changed off a sample point");

    property p_press_held;
        @(posedge clock) disable iff (rst)
            keys.newPress |-> |keys.keysHeld;
    endproperty
    a_press_held: assert property (p_press_held) else $error("press flagged with no key held");
endmodule

// ### kds_scanner.sv
/*
 * Key and display scanner top: strobe generation, return sampling, power-up display test
 * and key-detect pulse.
 * Assumes convClk is the 1 MHz converter clock and keyReturnLow comes straight from pins;
 * segmentIn comes from logic on the same clock.
 */
`timescale 1ns/100ps
`include "kds_map.svh"
module kds_scanner #(
    parameter int SLOT_TICKS   = `KDS_SLOT_TICKS,
    parameter int DEB_SCANS    = `KDS_DEB_SCANS,
    parameter int PULSE_CYC    = `KDS_PULSE_CYC,
    parameter int TEST_WIN_CYC = `KDS_TEST_WIN_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       convClk,
    input  wire logic [`KDS_NUM_RET-1:0]    keyReturnLow,
    input  wire logic [`KDS_SEG_W-1:0]      segmentIn,
    output var  kds_pkg::kds_sel_t          scanSelect,
    output var  logic [`KDS_NUM_DIGITS-1:0] digitStrobe,
    output var  logic [`KDS_NUM_DIGITS-1:0] digitDrive,
    output var  logic [`KDS_SEG_W-1:0]      segmentOut,
    output var  kds_pkg::kds_keys_t         keysHeld,
    output var  logic                       keyDetect,
    output var  logic                       displayTest,
    output var  logic                       selfTestStart
);
    import kds_pkg::*;

    localparam int PULSE_MAX_CYC = `KDS_PULSE_MAX_US * `KDS_CLK_MHZ;

    kds_keys_if keys ();

    logic                      convS1;
    logic                      convS2;
    logic                      convS3;
    logic                      scanTick;
    logic [7:0]                tickCnt;
    logic                      slotEnd;
    logic [`KDS_NUM_RET-1:0]   retS1;
    logic [`KDS_NUM_RET-1:0]   retS2;
    kds_sel_t                  next_scanSelect;
    kds_state_e                state;
    logic [23:0]               winCnt;
    logic [15:0]               pulseCnt;
    logic [15:0]               hiLen;

    function automatic logic [`KDS_NUM_DIGITS-1:0] decodeStrobe(input kds_sel_t sel);
        decodeStrobe = `KDS_NUM_DIGITS'(1) << sel;
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            convS1 <= 1'b0;
            convS2 <= 1'b0;
            convS3 <= 1'b0;
        end else if (ce) begin
            convS1 <= convClk;
            convS2 <= convS1;
            convS3 <= convS2;
        end
    end
    assign scanTick = convS2 & ~convS3;
    assign slotEnd  = scanTick && tickCnt == 8'(SLOT_TICKS - 1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tickCnt <= 8'h00;
        end else if (ce && scanTick) begin
            tickCnt <= slotEnd ? 8'h00 : tickCnt + 8'h01;
        end
    end

    // returns come from pins; two stages before the debouncer looks at them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            retS1 <= '1;
            retS2 <= '1;
        end else if (ce) begin
            retS1 <= keyReturnLow;
            retS2 <= retS1;
        end
    end

    always_comb begin
        next_scanSelect = scanSelect;
        if (slotEnd) begin
            next_scanSelect = scanSelect + 3'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scanSelect  <= '0;
            digitStrobe <= `KDS_STROBE_RST;
            digitDrive  <= `KDS_STROBE_RST;
        end else if (ce) begin
            scanSelect  <= next_scanSelect;
            digitStrobe <= decodeStrobe(next_scanSelect);
            digitDrive  <= decodeStrobe(next_scanSelect);
        end
    end

    // inverted strobe on return
    // sampling at the slot end leaves the whole slot for the return to settle
    assign keys.sampleNow = slotEnd;
    assign keys.slot      = scanSelect;
    assign keys.returnLow = ~retS2;

    kds_debounce #(
        .DEB_SCANS (DEB_SCANS)
    ) u_debounce (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .keys  (keys)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keysHeld <= '0;
        end else if (ce) begin
            keysHeld <= keys.keysHeld;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            winCnt <= 24'h000000;
        end else if (ce && state == ST_WINDOW) begin
            winCnt <= winCnt + 24'h000001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_WINDOW;
        end else if (ce) begin
            unique case (state)
                ST_WINDOW: begin
                    if (keys.newPress && keys.keysHeld[`KDS_KEY_REQUEST]) begin
                        state <= ST_TEST;
                    end else if (winCnt == 24'(TEST_WIN_CYC - 1)) begin
                        state <= ST_POWERUP;
                    end
                end
                ST_TEST: begin
                    if (keys.newPress) begin
                        state <= ST_POWERUP;
                    end
                end
                ST_POWERUP: state <= ST_NORMAL;
                ST_NORMAL:  state <= ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            displayTest   <= 1'b0;
            segmentOut    <= '0;
            selfTestStart <= 1'b0;
        end else if (ce) begin
            displayTest   <= state == ST_TEST;
            segmentOut    <= (state == ST_TEST) ? `KDS_SEG_ALL : segmentIn;
            selfTestStart <= state == ST_POWERUP;
        end
    end

    // key-detect pulse
    // a press during the pulse does not stretch it, so while ce stays high it never passes the upper limit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulseCnt  <= 16'h0000;
            keyDetect <= 1'b0;
        end else if (ce) begin
            if (keyDetect) begin
                if (pulseCnt == 16'(PULSE_CYC - 1)) begin
                    keyDetect <= 1'b0;
                    pulseCnt  <= 16'h0000;
                end else begin
                    pulseCnt <= pulseCnt + 16'h0001;
                end
            end else if (state == ST_NORMAL && keys.newPress) begin
                keyDetect <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hiLen <= 16'h0000;
        end else begin
            hiLen <= keyDetect ? hiLen + 16'h0001 : 16'h0000;
        end
    end

    property p_strobe_onehot;
        @(posedge clock) disable iff (rst) $onehot(digitStrobe);
    endproperty
    a_strobe_onehot: assert property (p_strobe_onehot) else $error("strobes not one-hot");

    property p_strobe_sel;
        @(posedge clock) disable iff (rst) digitStrobe == decodeStrobe(scanSelect);
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe does not match select code");

    property p_drive_match;
        @(posedge clock) disable iff (rst) digitDrive == digitStrobe;
    endproperty
    a_drive_match: assert property (p_drive_match) else $error("driver timing differs from strobe");

    property p_sel_on_tick;
        @(posedge clock) disable iff (rst) $changed(scanSelect) |-> $past(slotEnd) && $past(convS2);
    endproperty
    a_sel_on_tick: assert property (p_sel_on_tick) else $error("select moved without a converter tick");

    property p_enter_test;
        @(posedge clock) disable iff (rst)
            (ce && state == ST_WINDOW && keys.newPress && keys.keysHeld[`KDS_KEY_REQUEST])
            |=> state == ST_TEST ##1 (displayTest || !$past(ce));
    endproperty
    a_enter_test: assert property (p_enter_test) else $error("request key did not enter display test");

    property p_test_segs;
        @(posedge clock) disable iff (rst) displayTest |-> segmentOut == `KDS_SEG_ALL;
    endproperty
    a_test_segs: assert property (p_test_segs) else $error("segment off during display test");

    property p_release;
        @(posedge clock) disable iff (rst) (ce && state == ST_TEST && keys.newPress) |=> state == ST_POWERUP;
    endproperty
    a_release: assert property (p_release) else $error("key press did not release display test");

    property p_pulse_start;
        @(posedge clock) disable iff (rst)
            (ce && state == ST_NORMAL && keys.newPress && !keyDetect) |=> keyDetect;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("no key-detect pulse on press");

    property p_pulse_max;
        @(posedge clock) disable iff (rst) hiLen <= 16'(PULSE_MAX_CYC);
    endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("key-detect pulse too long");

    property p_no_pulse_test;
        @(posedge clock) disable iff (rst) (state != ST_NORMAL) |-> !keyDetect;
    endproperty
    a_no_pulse_test: assert property (p_no_pulse_test) else $error("key-detect outside normal operation");

    c_test_entered: cover property (@(posedge clock) disable iff (rst) state == ST_TEST);
    c_test_released: cover property (@(posedge clock) disable iff (rst) $past(state == ST_TEST) && state == ST_POWERUP);
    c_range20: cover property (@(posedge clock) disable iff (rst) keysHeld[`KDS_KEY_RANGE20]);
    c_detect: cover property (@(posedge clock) disable iff (rst) $fell(keyDetect));
endmodule

// ### kds_panel.sv
/*
 * Front panel key matrix model: one held key couples a strobe to a return line.
 * Assumes active-high strobes and active-low return lines with pull-ups.
 */
`timescale 1ns/100ps
`include "kds_map.svh"
module kds_panel (
    input  wire logic                       pressed,
    input  wire logic [4:0]                 keyIndex,
    input  wire logic [`KDS_NUM_DIGITS-1:0] digitStrobe,
    output var  logic [`KDS_NUM_RET-1:0]    keyReturnLow
);
    always_comb begin
        // released lines sit at the pull-up level
        keyReturnLow = 7'h7F;
        if (pressed) begin
            keyReturnLow[keyIndex % 7] = ~digitStrobe[keyIndex / 7];
        end
    end
endmodule

// ### testbench.sv
/*
 * Self-checking bench of the key and display scanner with a key matrix model.
 * Assumes shortened slot, window and pulse counts; convClk is made here at 1 MHz.
 */
`timescale 1ns/100ps
`include "kds_map.svh"
module testbench;
    import kds_pkg::*;
    localparam int SLOT  = 4;
    localparam int WIN   = 3000;
    localparam int PULSE = 500;
    localparam int HOLD  = 2000;
    logic       clock, rst, ce, convClk, pressed, started;
    logic [4:0] keyIndex;
    logic [7:0] segmentIn, segmentOut, digitStrobe, digitDrive, s;
    logic [6:0] keyReturnLow;
    kds_sel_t   scanSelect, lastSel;
    kds_keys_t  keysHeld;
    logic       keyDetect, displayTest, selfTestStart;
    int         n_errors, n_checks, cycles, nStart, k;
    kds_keys_t  qKeys[$];
    logic       qTest[$];
    logic       qDet[$];
    time        tLast, t0;

    kds_scanner #(.SLOT_TICKS(SLOT), .PULSE_CYC(PULSE), .TEST_WIN_CYC(WIN)) u_dut (
        .clock(clock), .rst(rst), .ce(ce), .convClk(convClk), .keyReturnLow(keyReturnLow),
        .segmentIn(segmentIn), .scanSelect(scanSelect), .digitStrobe(digitStrobe),
        .digitDrive(digitDrive), .segmentOut(segmentOut), .keysHeld(keysHeld),
        .keyDetect(keyDetect), .displayTest(displayTest), .selfTestStart(selfTestStart));
    kds_panel u_panel (.pressed(pressed), .keyIndex(keyIndex), .digitStrobe(digitStrobe),
        .keyReturnLow(keyReturnLow));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // converter clock, phase unrelated to the system clock
    initial begin
        convClk = 1'b0;
        #137;
        forever #500 convClk = ~convClk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmpKeys(input string what, input kds_keys_t e, input kds_keys_t g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmpVal(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // hold or release one key long enough for the debouncer to take it
    task automatic key(input int idx, input logic on);
        keyIndex = idx[4:0];
        pressed = on;
        qKeys.push_back(on ? kds_keys_t'(1) << idx : '0);
        repeat (HOLD) @(negedge clock);
    endtask
    // any wired key except request; index 13 has no key
    function automatic int pick();
        int p;
        p = 1 + ($urandom % 19);
        return (p >= 13) ? p + 1 : p;
    endfunction

    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            summarize();
        end
    end
    always @(negedge clock) segmentIn <= 8'($urandom);
    always @(posedge selfTestStart) nStart++;

    always @(keysHeld) if (started) begin
        cmpKeys("keysHeld", qKeys.size() ? qKeys.pop_front() : 'x, keysHeld);
    end
    always @(displayTest) if (started) begin
        cmpVal("displayTest", qTest.size() ? qTest.pop_front() : 1'bx, displayTest);
        if (displayTest === 1'b1) begin
            @(posedge clock);
            #1 cmpVal("segmentOut", 8'hFF, segmentOut);
        end
    end
    always @(posedge keyDetect) if (started) begin
        t0 = $time;
        cmpVal("keyDetect", qDet.size() ? qDet.pop_front() : 1'bx, 1'b1);
        @(negedge keyDetect);
        cmpVal("pulseCycles", PULSE, 32'(($time - t0) / 100));
    end
    always @(scanSelect) if (started) begin
        if (tLast != 0) cmpVal("slotCycles", SLOT * 10, 32'(($time - tLast) / 100));
        tLast = $time;
        #1;
        cmpVal("scanSelect", kds_sel_t'(lastSel + 1), scanSelect);
        cmpVal("digitStrobe", 8'h01 << scanSelect, digitStrobe);
        cmpVal("digitDrive", 8'h01 << scanSelect, digitDrive);
        lastSel = scanSelect;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        pressed = 1'b0;
        keyIndex = 5'h00;
        started = 1'b0;
        lastSel = '0;
        tLast = 0;
        k = $urandom(32'h17B6);
        repeat (16) @(negedge clock);
        cmpVal("rstStrobe", 8'h01, digitStrobe);
        cmpVal("rstSelect", 0, scanSelect);
        cmpVal("rstDetect", 0, keyDetect);
        rst = 1'b0;
        started = 1'b1;
        @(negedge clock);
        qTest.push_back(1'b1);
        key(0, 1'b1);
        key(0, 1'b0);
        k = pick();
        qTest.push_back(1'b0);
        key(k, 1'b1);
        key(k, 1'b0);
        cmpVal("selfTestStart", 1, nStart);
        @(posedge clock) s = segmentIn;
        #1 cmpVal("segmentNormal", s, segmentOut);
        qDet.push_back(1'b1);
        key(10, 1'b1);
        key(10, 1'b0);
        qDet.push_back(1'b1);
        key(0, 1'b1);
        key(0, 1'b0);
        repeat (4) begin
            k = pick();
            qDet.push_back(1'b1);
            key(k, 1'b1);
            key(k, 1'b0);
        end
        // a press shorter than the debounce span must not register
        keyIndex = 5'h05;
        pressed = 1'b1;
        repeat (320) @(negedge clock);
        pressed = 1'b0;
        repeat (HOLD) @(negedge clock);
        // second power-up left to run out its window: request then only gives a pulse
        @(negedge clock) started = 1'b0;
        rst = 1'b1;
        repeat (16) @(negedge clock);
        cmpVal("rstStrobe", 8'h01, digitStrobe);
        rst = 1'b0;
        lastSel = '0;
        tLast = 0;
        started = 1'b1;
        repeat (WIN + 4) @(negedge clock);
        cmpVal("selfTestStart", 2, nStart);
        qDet.push_back(1'b1);
        key(0, 1'b1);
        key(0, 1'b0);
        cmpVal("keysLeft", 0, qKeys.size());
        cmpVal("detectLeft", 0, qDet.size());
        cmpVal("testLeft", 0, qTest.size());
        summarize();
    end
endmodule
